// >>> rtl/mtc_core.sv
// Purpose: 16-bit modulo timer counter core with Wishbone register access
// Assumes: Classic Wishbone, 8-bit data in low bits of a 32-bit word
// Notes:   Channel capture and compare logic sits outside this core
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
module mtc_core #(
	parameter bit HAS_EXT_CLK = 1'b1
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// System state
	input  wire logic        stop_mode_i,
	input  wire logic        break_i,
	input  wire logic        break_clear_permit_i,
	// External count clock
	input  wire logic        external_count_clock_i,
	// Channel events from capture and compare logic
	input  wire logic [1:0]  chan_event_i,
	// Counter state to channel logic
	output logic      [15:0] count_o,
	output logic             overflow_o,
	// Interrupt requests
	output logic             overflow_irq_o,
	output logic [1:0]       chan_irq_o
);
	typedef struct packed {
		logic                 ack;
		logic [31:0]          rdat;
		logic [15:0]          count;
		logic [5:0]           pre;
		logic [15:0]          wrap;
		logic [7:0]           wrap_hi_pend;
		logic                 wrap_lock;
		logic [7:0]           low_buf;
		logic                 low_latched;
		logic                 overflow_flag;
		logic                 overflow_irq_enable;
		logic                 counter_halt;
		logic [2:0]           clock_divide_select;
		mtc_pkg::mtc_clr_e    ovf_arm;
		logic [1:0]           channel_event_flag;
		logic [1:0]           channel_irq_enable;
		logic [1:0]           ch_arm;
		logic                 ovf_pulse;
		logic                 ovf_irq;
		logic [1:0]           ch_irq;
	} mtc_core_s;

	mtc_core_s st_ff;
	mtc_core_s nxt_st;
	logic      ext_rise;

	// ****************************************
	// External clock edge detect
	// ****************************************
	mtc_ext_sync u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ext_i  (external_count_clock_i),
		.rise_o (ext_rise)
	);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic pre_tick(input logic [2:0] sel, input logic [5:0] pre,
		input logic ext);
		logic [5:0] mask;
		mask = 6'h3f;
		if (sel == mtc_pkg::PS_EXT) begin
			pre_tick = ext & HAS_EXT_CLK;
		end else begin
			// Divide by 2^sel: tick when the low sel prescaler bits are all ones
			mask     = 6'h3f >> (3'h6 - sel);
			pre_tick = &(pre | ~mask);
		end
	endfunction

	function automatic logic flag_clear(input logic armed, input logic wbit,
		input logic brk, input logic permit);
		flag_clear = armed & ~wbit & (~brk | permit);
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic       req;
		logic       wr;
		logic       rd;
		logic [7:0] wb;
		logic       tick;
		logic       run;
		logic       hit;
		logic       clr;
		logic [7:0] rv;
		logic       touch;
		req   = cyc_i & stb_i & ~st_ff.ack;
		wr    = req & we_i & sel_i[0];
		rd    = req & ~we_i;
		wb    = dat_i[7:0];
		nxt_st = st_ff;
		nxt_st.ack = req;
		nxt_st.ovf_pulse = 1'b0;
		touch = ~break_i | break_clear_permit_i;
		clr   = wr && adr_i == mtc_pkg::ADR_CTRL_STAT && wb[mtc_pkg::BIT_CLR];

		// Stop mode and break both freeze counting; registers are kept
		run  = ~st_ff.counter_halt & ~stop_mode_i & ~break_i;
		tick = run & pre_tick(st_ff.clock_divide_select, st_ff.pre, ext_rise);
		hit  = tick & (st_ff.count == st_ff.wrap);
		if (run) begin
			nxt_st.pre = st_ff.pre + 6'h01;
		end
		if (tick) begin
			nxt_st.count = hit ? mtc_pkg::RST_COUNT : st_ff.count + 16'h0001;
		end
		if (hit & ~st_ff.wrap_lock) begin
			nxt_st.ovf_pulse = 1'b1;
		end

		// Register reads
		rv = 8'h00;
		unique case (adr_i)
			mtc_pkg::ADR_CTRL_STAT: rv = {st_ff.overflow_flag, st_ff.overflow_irq_enable,
				st_ff.counter_halt, 2'b00, st_ff.clock_divide_select};
			mtc_pkg::ADR_CNT_HIGH:  rv = st_ff.count[15:8];
			mtc_pkg::ADR_CNT_LOW:   rv = st_ff.low_latched ? st_ff.low_buf : st_ff.count[7:0];
			mtc_pkg::ADR_WRAP_HIGH: rv = st_ff.wrap[15:8];
			mtc_pkg::ADR_WRAP_LOW:  rv = st_ff.wrap[7:0];
			mtc_pkg::ADR_CHAN_CTRL: rv = {2'b00, st_ff.channel_irq_enable, 2'b00,
				st_ff.channel_event_flag};
			default:                rv = 8'h00;
		endcase
		nxt_st.rdat = req ? {24'h000000, rv} : 32'h00000000;

		if (rd) begin
			unique case (adr_i)
				mtc_pkg::ADR_CTRL_STAT: begin
					if (st_ff.overflow_flag & touch) begin
						nxt_st.ovf_arm = mtc_pkg::MTC_CLR_ARMED;
					end
				end
				mtc_pkg::ADR_CNT_HIGH: begin
					if (!st_ff.low_latched) begin
						nxt_st.low_buf     = st_ff.count[7:0];
						nxt_st.low_latched = 1'b1;
					end
				end
				mtc_pkg::ADR_CNT_LOW:  nxt_st.low_latched = 1'b0;
				mtc_pkg::ADR_CHAN_CTRL: begin
					if (touch) begin
						nxt_st.ch_arm = st_ff.channel_event_flag;
					end
				end
				default: ;
			endcase
		end

		// Register writes
		if (wr) begin
			unique case (adr_i)
				mtc_pkg::ADR_CTRL_STAT: begin
					nxt_st.overflow_irq_enable = wb[mtc_pkg::BIT_OVIE];
					nxt_st.counter_halt        = wb[mtc_pkg::BIT_HALT];
					nxt_st.clock_divide_select = wb[mtc_pkg::BIT_PS_HI:0];
					if (flag_clear(st_ff.ovf_arm == mtc_pkg::MTC_CLR_ARMED,
						wb[mtc_pkg::BIT_OVF], break_i, break_clear_permit_i)) begin
						nxt_st.overflow_flag = 1'b0;
					end
					if (touch) begin
						nxt_st.ovf_arm = mtc_pkg::MTC_CLR_IDLE;
					end
				end
				mtc_pkg::ADR_WRAP_HIGH: begin
					nxt_st.wrap_hi_pend = wb;
					nxt_st.wrap_lock    = 1'b1;
				end
				mtc_pkg::ADR_WRAP_LOW: begin
					nxt_st.wrap      = {st_ff.wrap_lock ? st_ff.wrap_hi_pend : st_ff.wrap[15:8],
						wb};
					nxt_st.wrap_lock = 1'b0;
				end
				mtc_pkg::ADR_CHAN_CTRL: begin
					nxt_st.channel_irq_enable = wb[mtc_pkg::BIT_CH1IE:mtc_pkg::BIT_CH0IE];
					for (int i = 0; i < 2; i++) begin
						if (flag_clear(st_ff.ch_arm[i], wb[i], break_i, break_clear_permit_i)) begin
							nxt_st.channel_event_flag[i] = 1'b0;
						end
					end
					if (touch) begin
						nxt_st.ch_arm = 2'b00;
					end
				end
				default: ;
			endcase
		end

		// Clear bit is write-only and never stored; halt in the same write still applies
		if (clr) begin
			nxt_st.count = mtc_pkg::RST_COUNT;
			nxt_st.pre   = mtc_pkg::RST_PRE;
		end

		// Events beat a clear in the same cycle and disarm the pending clear
		if (nxt_st.ovf_pulse) begin
			nxt_st.overflow_flag = 1'b1;
			nxt_st.ovf_arm       = mtc_pkg::MTC_CLR_IDLE;
		end
		// Capture or compare events arrive alike from the channel logic
		for (int i = 0; i < 2; i++) begin
			if (chan_event_i[i] & ~stop_mode_i) begin
				nxt_st.channel_event_flag[i] = 1'b1;
				nxt_st.ch_arm[i]             = 1'b0;
			end
		end

		// Requests stay live in wait mode so they can wake the core
		nxt_st.ovf_irq = nxt_st.overflow_flag & nxt_st.overflow_irq_enable;
		nxt_st.ch_irq  = nxt_st.channel_event_flag & nxt_st.channel_irq_enable;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff                     <= '0;
			st_ff.wrap                <= mtc_pkg::RST_WRAP;
			st_ff.counter_halt        <= 1'b1;
			st_ff.ovf_arm             <= mtc_pkg::MTC_CLR_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign ack_o          = st_ff.ack;
	assign dat_o          = st_ff.rdat;
	assign count_o        = st_ff.count;
	assign overflow_o     = st_ff.ovf_pulse;
	assign overflow_irq_o = st_ff.ovf_irq;
	assign chan_irq_o     = st_ff.ch_irq;
endmodule // mtc_core

// >>> shared/mtc_pkg.sv
// Purpose: Constants and types for the modulo timer counter core
// Assumes: 8-bit registers on classic Wishbone, one word per register
// Notes:   Offsets are byte addresses of aligned 32-bit words
package mtc_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADR_CTRL_STAT  = 8'h00;
	localparam logic [7:0] ADR_CNT_HIGH   = 8'h04;
	localparam logic [7:0] ADR_CNT_LOW    = 8'h08;
	localparam logic [7:0] ADR_WRAP_HIGH  = 8'h0c;
	localparam logic [7:0] ADR_WRAP_LOW   = 8'h10;
	localparam logic [7:0] ADR_CHAN_CTRL  = 8'h14;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_OVF   = 7;
	localparam int BIT_OVIE  = 6;
	localparam int BIT_HALT  = 5;
	localparam int BIT_CLR   = 4;
	localparam int BIT_PS_HI = 2;
	localparam int BIT_CH0F  = 0;
	localparam int BIT_CH1F  = 1;
	localparam int BIT_CH0IE = 4;
	localparam int BIT_CH1IE = 5;

	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic [15:0] RST_WRAP  = 16'hffff;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [2:0]  PS_EXT    = 3'h7;
	localparam logic [5:0]  RST_PRE   = 6'h00;

	typedef enum logic [1:0] {
		MTC_CLR_IDLE  = 2'b00,
		MTC_CLR_ARMED = 2'b01
	} mtc_clr_e;

endpackage

// >>> rtl/mtc_ext_sync.sv
// Purpose: Synchronise the external count clock and detect rising edges
// Assumes: Input toggles at no more than half the bus clock rate
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module mtc_ext_sync (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Pin and edge
	input  wire logic ext_i,
	output logic      rise_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic rise;
	} mtc_sync_s;

	mtc_sync_s st_ff;
	mtc_sync_s nxt_st;

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.s1   = ext_i;
		nxt_st.s2   = st_ff.s1;
		nxt_st.s3   = st_ff.s2;
		nxt_st.rise = st_ff.s2 & ~st_ff.s3;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rise_o = st_ff.rise;
endmodule // mtc_ext_sync

// >>> tb/mtc_core_monitor.sv
// Purpose: Port checks of the timer core
// Assumes: One clock, sync reset
// Notes:   Watches only the core ports
`timescale 1ns/1ns
module mtc_core_monitor (
	// Clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic        ack_o,
	// System and counter
	input wire logic        stop_mode_i,
	input wire logic        break_i,
	input wire logic [15:0] count_o,
	input wire logic        overflow_o,
	input wire logic        overflow_irq_o,
	input wire logic [1:0]  chan_irq_o
);
	// ****
	// Checks
	// ****
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic wr;
	logic hi_ff;
	logic nxt_hi;
	assign wr = ack_o && we_i && sel_i[0];
	// Tracks a high limit write waiting for its low half
	always_comb begin
		nxt_hi = hi_ff;
		if (wr && adr_i == mtc_pkg::ADR_WRAP_HIGH) nxt_hi = 1'b1;
		if (wr && adr_i == mtc_pkg::ADR_WRAP_LOW) nxt_hi = 1'b0;
	end
	always_ff @(posedge clk_i) hi_ff <= rst_i ? 1'b0 : nxt_hi;
	property p_wrap; overflow_o |-> count_o == 16'h0000; endproperty
	a_wrap: assert property (p_wrap) else $error("wrap not zero");
	property p_step; count_o != $past(count_o) |-> count_o == $past(count_o) + 16'h0001 ||
		count_o == 16'h0000; endproperty
	a_step: assert property (p_step) else $error("bad step");
	property p_rst; $fell(rst_i) |-> !overflow_irq_o && chan_irq_o == 2'h0; endproperty
	a_rst: assert property (p_rst) else $error("irq after reset");
	property p_stop; stop_mode_i |=> $stable(count_o); endproperty
	a_stop: assert property (p_stop) else $error("count in stop");
	property p_brk; break_i |=> $stable(count_o); endproperty
	a_brk: assert property (p_brk) else $error("count in break");
	property p_supp; hi_ff |-> !overflow_o; endproperty
	a_supp: assert property (p_supp) else $error("overflow not held");
	property p_clr; wr && adr_i == mtc_pkg::ADR_CTRL_STAT && dat_i[4] |-> ##[0:1]
		count_o == 16'h0000; endproperty
	a_clr: assert property (p_clr) else $error("clear missed");
	property p_hclr; wr && adr_i == mtc_pkg::ADR_CTRL_STAT && dat_i[5] && dat_i[4] |=>
		(count_o == 16'h0000) [*3]; endproperty
	a_hclr: assert property (p_hclr) else $error("halt clear moved");
endmodule // mtc_core_monitor
bind mtc_core mtc_core_monitor u_mon (.*);

// >>> tb/mtc_far_model.sv
// Purpose: Far side: count clock and channel events
// Assumes: Bench pulses ev_i one cycle per event
// Notes:   Count clock stands low while run_i is low
`timescale 1ns/1ns
module mtc_far_model (
	// Control
	input  wire logic       clk_i,
	input  wire logic       run_i,
	input  wire logic [1:0] ev_i,
	// Toward the core
	output logic            ext_o,
	output logic [1:0]      chan_o
);
	// ****
	// Sources
	// ****
	logic [1:0] ph_ff;
	always_ff @(posedge clk_i) begin
		ph_ff <= run_i ? ph_ff + 2'h1 : 2'h0;
		chan_o <= ev_i;
	end
	// Two cycles per half period keeps under half the bus rate
	assign ext_o = ph_ff[1];
endmodule // mtc_far_model

// >>> tb/tb.sv
// Purpose: Register bench of the timer core
// Assumes: Wrap 4 keeps overflow periods short
// Notes:   Bus waits are bounded
`timescale 1ns/1ns
module tb;
	// ****
	// Bench
	// ****
	localparam logic [7:0] CS = mtc_pkg::ADR_CTRL_STAT;
	localparam logic [7:0] WH = mtc_pkg::ADR_WRAP_HIGH;
	localparam logic [7:0] WL = mtc_pkg::ADR_WRAP_LOW;
	localparam logic [7:0] CC = mtc_pkg::ADR_CHAN_CTRL;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, run = 1'b0;
	logic stop_mode_i = 1'b0, break_i = 1'b0, break_clear_permit_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [1:0] ev = 2'h0;
	logic [31:0] dat_o;
	logic [15:0] count_o;
	logic ack_o, external_count_clock_i, overflow_o, overflow_irq_o;
	logic [1:0] chan_event_i, chan_irq_o;
	logic [7:0] rd, l1;
	int errors = 0, check_count = 0, cyc_n = 0, n;
	always #50 clk_i = ~clk_i;
	mtc_core DUT (.*);
	mtc_far_model u_far (.clk_i(clk_i), .run_i(run), .ev_i(ev),
		.ext_o(external_count_clock_i), .chan_o(chan_event_i));
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// Request held until ack is sampled high, then released
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i} <= {2'h3, w, a, 4'h1};
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 20);
		if (ack_o !== 1'b1) begin
			errors++;
			tally_and_finish();
		end
		rd = dat_o[7:0];
		{cyc_i, stb_i} <= 2'h0;
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(nm, {8'h00, e}, {8'h00, rd});
	endtask
	task automatic wait_ovf(output int c);
		c = 0;
		do begin
			@(posedge clk_i);
			c++;
		end while (overflow_o !== 1'b1 && c < 1000);
		if (overflow_o !== 1'b1) begin
			errors++;
			tally_and_finish();
		end
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rc("ctrl", CS, 8'h20);
		rc("wrap", WH, 8'hff);
		rc("cnt", mtc_pkg::ADR_CNT_HIGH, 8'h00);
		wb(1'b1, WH, 8'h00);
		wb(1'b1, WL, 8'h04);
		wb(1'b1, CS, 8'h40);
		repeat (12) @(posedge clk_i);
		chk("irq", 16'h0001, {15'h0, overflow_irq_o});
		// Zero write without a prior read must not clear
		wb(1'b1, CS, 8'h60);
		rc("unarmed", CS, 8'he0);
		break_i <= 1'b1;
		wb(1'b1, CS, 8'h60);
		rc("brk", CS, 8'he0);
		break_i <= 1'b0;
		wb(1'b1, CS, 8'h60);
		rc("cleared", CS, 8'h60);
		chk("irq_off", 16'h0000, {15'h0, overflow_irq_o});
		wb(1'b1, CS, 8'h30);
		chk("count_o", 16'h0000, count_o);
		rc("cnt0", mtc_pkg::ADR_CNT_LOW, 8'h00);
		rc("trst", CS, 8'h20);
		for (int p = 0; p < 8; p++) begin
			run <= (p == 7);
			wb(1'b1, CS, p[7:0]);
			wait_ovf(n);
			wait_ovf(n);
			chk("period", (p == 7) ? 16'h0014 : 16'h0005 << p, n[15:0]);
		end
		run <= 1'b0;
		wb(1'b1, CS, 8'h30);
		wb(1'b0, CS, 8'h00);
		wb(1'b1, CS, 8'h20);
		wb(1'b1, WH, 8'h00);
		wb(1'b1, CS, 8'h00);
		repeat (30) @(posedge clk_i);
		rc("supp", CS, 8'h00);
		wb(1'b1, WL, 8'h04);
		stop_mode_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		{stop_mode_i, break_i} <= 2'h1;
		repeat (10) @(posedge clk_i);
		break_i <= 1'b0;
		wb(1'b1, CS, 8'h30);
		wb(1'b1, WH, 8'hff);
		wb(1'b1, WL, 8'hff);
		wb(1'b1, CS, 8'h00);
		wb(1'b0, mtc_pkg::ADR_CNT_HIGH, 8'h00);
		repeat (20) @(posedge clk_i);
		wb(1'b1, CS, 8'h20);
		wb(1'b0, mtc_pkg::ADR_CNT_HIGH, 8'h00);
		wb(1'b0, mtc_pkg::ADR_CNT_LOW, 8'h00);
		l1 = rd;
		wb(1'b0, mtc_pkg::ADR_CNT_LOW, 8'h00);
		chk("latch", 16'h0001, {15'h0, rd - l1 >= 8'h14 && rd - l1 <= 8'h28});
		wb(1'b1, CC, 8'h10);
		ev <= 2'h3;
		@(posedge clk_i);
		ev <= 2'h0;
		repeat (3) @(posedge clk_i);
		chk("chan_irq", 16'h0001, {14'h0, chan_irq_o});
		rc("chan", CC, 8'h13);
		{break_i, break_clear_permit_i} <= 2'h3;
		wb(1'b0, CC, 8'h00);
		wb(1'b1, CC, 8'h10);
		break_i <= 1'b0;
		rc("chan_clr", CC, 8'h10);
		rc("unmapped", 8'h20, 8'h00);
		tally_and_finish();
	end
endmodule // tb
